// file: hw/dtcca_top.sv
// Two reloadable time bases and a capture/compare channel array with one pin each.
// Assumes all inputs synchronous to CLK_SYS_IN; config ports held by the system.
`timescale 1ns/1ps

module dtcca_top
  import dtcca_pkg::*;
#(
  parameter int CH_N = CH_NUM
) (
  input  wire logic                          CLK_SYS_IN,
  input  wire logic                          RESET_IN,
  input  wire logic                          STAGGER_IN,
  input  wire dtcca_tb_cfg_t [TB_NUM-1:0]    TB_CFG_IN,
  input  wire logic [TB_NUM-1:0][TB_W-1:0]   TB_RELOAD_IN,
  input  wire logic                          NEIGHBOUR_TIMER_OVERFLOW_SOURCE_IN,
  input  wire logic                          EXT_COUNT_IN,
  input  wire dtcca_ch_cfg_t [CH_N-1:0]      CH_CFG_IN,
  input  wire logic [CH_N-1:0]               CH_WR_IN,
  input  wire logic [TB_W-1:0]               CH_WDATA_IN,
  input  wire logic [CH_N/2-1:0]             DOUBLE_IN,
  input  wire logic [CH_N-1:0]               CH_PIN_IN,
  output wire logic [CH_N-1:0]               CH_PIN_OUT,
  output wire logic [CH_N-1:0]               CH_PIN_OE_OUT,
  output wire logic [CH_N-1:0]               CH_IRQ_OUT,
  output wire logic [CH_N-1:0][TB_W-1:0]     CH_VALUE_OUT,
  output wire logic [TB_NUM-1:0][TB_W-1:0]   TB_VALUE_OUT,
  output wire logic [TB_NUM-1:0]             TB_OVF_OUT
);

  localparam int H = CH_N / 2;

  if (CH_N < 2 || CH_N > CH_NUM || (CH_N % 2) != 0) begin : gen_chk
    $error("CH_N must be even and between 2 and 16");
  end

  function automatic logic presc_hit(input logic [DIV_W-1:0] d, input logic [2:0] k);
    logic [DIV_W-1:0] m;
    m = (DIV_W'(1) << k) - DIV_W'(1);
    return (d & m) == m;
  endfunction : presc_hit

  //////////////////////////////////////////////////////////////////////////////
  // Shared prescaler, stagger phase, external count edge

  logic [DIV_W-1:0] div;
  logic [2:0]       phase;
  logic             ext_q;
  wire              ext_rise   = EXT_COUNT_IN & ~ext_q;
  wire              slot_open  = ~STAGGER_IN | (phase == STAGGER_LAST);

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      div   <= '0;
      phase <= '0;
      ext_q <= 1'h0;
    end else begin
      div   <= div + DIV_W'(1);
      phase <= phase + 3'h1;
      ext_q <= EXT_COUNT_IN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Time bases

  logic [TB_NUM-1:0][TB_W-1:0] tb_value;
  logic [TB_NUM-1:0]           tb_tick;
  logic [TB_NUM-1:0]           tb_ovf;
  logic [TB_NUM-1:0]           tb_upd;

  for (genvar t = 0; t < TB_NUM; t++) begin : gen_tb
    logic [TB_W-1:0] value;
    logic            upd;
    logic            src_tick;

    always_comb begin
      unique case (TB_CFG_IN[t].src)
        DTCCA_SRC_PRESCALE:  src_tick = presc_hit(div, TB_CFG_IN[t].pre);
        DTCCA_SRC_NEIGHBOUR: src_tick = NEIGHBOUR_TIMER_OVERFLOW_SOURCE_IN;
        DTCCA_SRC_EXT:       src_tick = (t == 0) & ext_rise;
        default:             src_tick = 1'h0;
      endcase
    end

    // Stagger gating also drops neighbour/external ticks outside the slot
    assign tb_tick[t] = TB_CFG_IN[t].run & src_tick & slot_open;
    assign tb_ovf[t]  = tb_tick[t] & (value == TB_MAX);

    always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
        value <= TB_RESET;
        upd   <= 1'h0;
      end else begin
        upd <= tb_tick[t];
        if (tb_ovf[t]) begin
          value <= TB_RELOAD_IN[t];
        end else if (tb_tick[t]) begin
          value <= value + TB_W'(1);
        end
      end
    end

    assign tb_value[t]     = value;
    assign tb_upd[t]       = upd;
    assign TB_VALUE_OUT[t] = value;
    assign TB_OVF_OUT[t]   = tb_ovf[t];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel array

  logic [CH_N-1:0] match_evt;
  logic [CH_N-1:0] cap_evt;
  logic [CH_N-1:0] done_vec;
  logic [CH_N-1:0] spent_vec;

  for (genvar i = 0; i < CH_N; i++) begin : gen_ch
    logic [TB_W-1:0] value;
    logic            pin_q;
    logic            pin;
    logic            done;
    logic            spent;
    logic            irq;
    logic            dbl_lead;
    logic            dbl_part;
    logic            part_match;
    logic            next_pin;

    wire dtcca_ch_cfg_t cfg  = CH_CFG_IN[i];
    wire                tsel = cfg.tb_sel;
    wire [TB_W-1:0]     tnow = tb_value[tsel];
    wire                rise = CH_PIN_IN[i] & ~pin_q;
    wire                fall = ~CH_PIN_IN[i] & pin_q;
    wire                once = (cfg.mode == DTCCA_CMP_IRQ_ONCE) | (cfg.mode == DTCCA_CMP_SET_CLEAR);
    wire                m3   = cfg.mode == DTCCA_CMP_SET_CLEAR;

    if (i < H) begin : gen_lead
      assign dbl_lead   = DOUBLE_IN[i];
      assign dbl_part   = 1'h0;
      assign part_match = match_evt[i+H];
    end else begin : gen_part
      assign dbl_lead   = 1'h0;
      assign dbl_part   = DOUBLE_IN[i-H];
      assign part_match = 1'h0;
    end

    assign cap_evt[i] = cfg.capture &
                        ((cfg.edge_sel[EDGE_RISE] & rise) | (cfg.edge_sel[EDGE_FALL] & fall));
    // Checked only on the cycle after a tick, so one hit per timer value
    assign match_evt[i] = ~cfg.capture & tb_upd[tsel] & (tnow == value)
                          & ~spent
                          & ~(once & done);

    wire toggle = dbl_lead ? (match_evt[i] | part_match)
                           : (cfg.mode == DTCCA_CMP_TOGGLE) & match_evt[i];

    always_comb begin
      next_pin = pin;
      if (!cfg.capture) begin
        if (toggle) begin
          next_pin = ~pin;
        end else if (m3 & match_evt[i]) begin
          next_pin = 1'h1;
        end else if (m3 & tb_ovf[tsel]) begin
          next_pin = 1'h0;
        end
      end
    end

    always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
        value <= CH_RESET;
        pin_q <= 1'h0;
        pin   <= PIN_RESET;
        done  <= 1'h0;
        spent <= 1'h0;
        irq   <= 1'h0;
      end else begin
        pin_q <= CH_PIN_IN[i];
        pin   <= next_pin;
        irq   <= cap_evt[i] | match_evt[i];
        // Capture beats a same-cycle software write
        if (cap_evt[i]) begin
          value <= tnow;
        end else if (CH_WR_IN[i]) begin
          value <= CH_WDATA_IN;
        end
        if (match_evt[i]) begin
          done <= 1'h1;
        end else if (tb_ovf[tsel]) begin
          done <= 1'h0;
        end
        if ((match_evt[i] | cap_evt[i]) & cfg.single) begin
          spent <= 1'h1;
        end else if (CH_WR_IN[i]) begin
          spent <= 1'h0;
        end
      end
    end

    assign CH_VALUE_OUT[i]  = value;
    assign CH_PIN_OUT[i]    = pin;
    assign CH_IRQ_OUT[i]    = irq;
    // Mode 0 and 2 leave the pin to the port, except on the lead channel of a double pair
    assign CH_PIN_OE_OUT[i] = ~cfg.capture & ~dbl_part &
                              (dbl_lead | (cfg.mode == DTCCA_CMP_TOGGLE) | m3);
    assign done_vec[i]      = done;
    assign spent_vec[i]     = spent;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks on time base 0 and on the channels the bench sets up per mode

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  AST_RELOAD: assert property (
    tb_ovf[0] |=> tb_value[0] == $past(TB_RELOAD_IN[0]))
    else $error("time base did not reload on overflow");

  AST_CAPTURE: assert property (
    cap_evt[8] |=> CH_VALUE_OUT[8] == $past(tb_value[CH_CFG_IN[8].tb_sel]) && CH_IRQ_OUT[8])
    else $error("capture did not latch time base or interrupt");

  AST_EDGE_RISE_ONLY: assert property (
    CH_CFG_IN[8].capture && CH_CFG_IN[8].edge_sel == 2'h1 && !CH_PIN_IN[8] |-> !cap_evt[8])
    else $error("capture on wrong edge");

  AST_TOGGLE: assert property (
    match_evt[1] && CH_CFG_IN[1].mode == DTCCA_CMP_TOGGLE && !DOUBLE_IN[1]
      |=> CH_PIN_OUT[1] != $past(CH_PIN_OUT[1]))
    else $error("mode 1 pin did not toggle");

  AST_MODE0_PIN: assert property (
    !CH_CFG_IN[0].capture && CH_CFG_IN[0].mode == DTCCA_CMP_IRQ_ALL && !DOUBLE_IN[0]
      |-> !CH_PIN_OE_OUT[0])
    else $error("mode 0 drives the pin");

  AST_MODE3_SET: assert property (
    match_evt[3] && CH_CFG_IN[3].mode == DTCCA_CMP_SET_CLEAR |=> CH_PIN_OUT[3])
    else $error("mode 3 pin not set on match");

  AST_ONCE: assert property (
    done_vec[2] && CH_CFG_IN[2].mode == DTCCA_CMP_IRQ_ONCE |-> !match_evt[2])
    else $error("second compare event in one period");

  AST_STAGGER: assert property (
    STAGGER_IN && phase != STAGGER_LAST |-> !tb_tick[0])
    else $error("time base ticked outside stagger slot");

  AST_MATCH_IRQ: assert property (
    match_evt[0] |=> CH_IRQ_OUT[0] ##1 !CH_IRQ_OUT[0] || match_evt[0] || cap_evt[0])
    else $error("compare match without interrupt");

  AST_SINGLE: assert property (
    spent_vec[4] && !CH_WR_IN[4] |=> !match_evt[4])
    else $error("single event channel fired again");

  COV_CAPTURE: cover property (cap_evt[8] ##1 CH_IRQ_OUT[8]);
  COV_OVF_RELOAD: cover property (tb_ovf[0] ##1 tb_upd[0]);
  COV_MODE3: cover property (match_evt[3] && CH_CFG_IN[3].mode == DTCCA_CMP_SET_CLEAR);
  COV_DOUBLE: cover property (DOUBLE_IN[5] && match_evt[5+H]);

endmodule : dtcca_top

// file: include/dtcca_pkg.sv
// Constants and carrier types for the dual time base capture/compare array.
// Assumes one system clock and a synchronous active-high reset.
package dtcca_pkg;

  localparam int          TB_W         = 16;
  localparam int          TB_NUM       = 2;
  localparam int          CH_NUM       = 16;
  localparam int          DIV_W        = 8;
  localparam int          EDGE_RISE    = 0;
  localparam int          EDGE_FALL    = 1;
  localparam logic [2:0]  STAGGER_LAST = 3'h7;
  localparam logic [15:0] TB_RESET     = 16'h0000;
  localparam logic [15:0] TB_MAX       = 16'hffff;
  localparam logic [15:0] CH_RESET     = 16'h0000;
  localparam logic        PIN_RESET    = 1'h0;

  typedef enum logic [1:0] {
    DTCCA_CMP_IRQ_ALL,
    DTCCA_CMP_TOGGLE,
    DTCCA_CMP_IRQ_ONCE,
    DTCCA_CMP_SET_CLEAR
  } dtcca_cmp_t;

  typedef enum logic [1:0] {
    DTCCA_SRC_PRESCALE,
    DTCCA_SRC_NEIGHBOUR,
    DTCCA_SRC_EXT
  } dtcca_src_t;

  typedef struct packed {
    logic       run;
    dtcca_src_t src;
    logic [2:0] pre;
  } dtcca_tb_cfg_t;

  typedef struct packed {
    logic       capture;
    logic       tb_sel;
    logic [1:0] edge_sel;
    dtcca_cmp_t mode;
    logic       single;
  } dtcca_ch_cfg_t;

endpackage : dtcca_pkg

// file: verif/dtcca_pin_model.sv
// Far side of the channel pins: outside drivers meet the device outputs.
// Assumes the device drives a pin only while its enable is high.
`timescale 1ns/1ps
module dtcca_pin_model (
  input  wire logic [15:0] pin_out_in,
  input  wire logic [15:0] oe_in,
  input  wire logic [15:0] drv_in,
  output wire logic [15:0] pin_in_out
);
  // Device wins where enabled, outside level elsewhere
  assign pin_in_out = (oe_in & pin_out_in) | (~oe_in & drv_in);
endmodule : dtcca_pin_model

// file: verif/dual_timer_capture_compare_array_bench.sv
// Bench for the capture/compare array: time bases, compare modes, capture.
// Assumes pins close through the pin model; inputs change 1 ns after the edge.
`timescale 1ns/1ps
module dual_timer_capture_compare_array_bench import dtcca_pkg::*;;
  logic                clk, rst, stag, neigh, ext;
  dtcca_tb_cfg_t [1:0] tcfg;
  logic [1:0][15:0]    rld, tval, tv_q;
  dtcca_ch_cfg_t [15:0] ccfg;
  logic [15:0]         wr, wdat, drv, pin, pout, oe, irq, pin_q, v;
  logic [7:0]          dbl;
  logic [15:0][15:0]   cval;
  logic [1:0]          ovf;
  int                  err_count, cmp_count, cyc, chg[2], nirq[16], ntog[16], nrise[16];
  int                  si[16], st[16], sr[16], sc[2];
  dtcca_top dut (.CLK_SYS_IN(clk), .RESET_IN(rst), .STAGGER_IN(stag), .TB_CFG_IN(tcfg), .TB_RELOAD_IN(rld),
    .NEIGHBOUR_TIMER_OVERFLOW_SOURCE_IN(neigh), .EXT_COUNT_IN(ext), .CH_CFG_IN(ccfg), .CH_WR_IN(wr),
    .CH_WDATA_IN(wdat), .DOUBLE_IN(dbl), .CH_PIN_IN(pin), .CH_PIN_OUT(pout), .CH_PIN_OE_OUT(oe),
    .CH_IRQ_OUT(irq), .CH_VALUE_OUT(cval), .TB_VALUE_OUT(tval), .TB_OVF_OUT(ovf));
  dtcca_pin_model pm (.pin_out_in(pout), .oe_in(oe), .drv_in(drv), .pin_in_out(pin));
  ////////////////////////////////////////////////////////////
  // Event counters sample settled values of the previous cycle
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 16; i++) begin
      nirq[i] <= nirq[i] + (irq[i] === 1'b1);
      ntog[i] <= ntog[i] + (pout[i] !== pin_q[i]);
      nrise[i] <= nrise[i] + (pout[i] === 1'b1 && pin_q[i] === 1'b0);
    end
    for (int i = 0; i < 2; i++) chg[i] <= chg[i] + (tval[i] !== tv_q[i]);
    pin_q <= pout;
    tv_q <= tval;
    // First overflow alone needs 65536 cycles
    if (cyc == 80000) begin
      err_count++;
      finish_test();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  function automatic dtcca_ch_cfg_t cc(input logic c, t, input logic [1:0] e, m, input logic s);
    cc = '{capture: c, tb_sel: t, edge_sel: e, mode: dtcca_cmp_t'(m), single: s};
  endfunction : cc
  function automatic dtcca_tb_cfg_t tb(input dtcca_src_t s, input logic [2:0] p);
    tb = '{run: 1'b1, src: s, pre: p};
  endfunction : tb
  task wrch(input logic [15:0] m, input logic [15:0] d);
    tick(1);
    wr = m;
    wdat = d;
    tick(1);
    wr = '0;
  endtask : wrch
  ////////////////////////////////////////////////////////////
  task t_reload;
    chk(tval[0], TB_RESET);
    chk(pout, 16'h0000);
    rld = {16'h0000, 16'hfff0};
    tcfg = {tb(DTCCA_SRC_PRESCALE, 3'h0), tb(DTCCA_SRC_PRESCALE, 3'h0)};
    tick(1);
    tcfg[1] = '0;
    while (ovf[0] !== 1'b1) tick(1);
    tick(1);
    chk(tval[0], 16'hfff0);
  endtask : t_reload
  task t_modes;
    dtcca_ch_cfg_t [15:0] c;
    c = '0;
    wrch(16'h001f, 16'hfff4);
    wrch(16'h0020, 16'hfff2);
    wrch(16'h2040, 16'hfffa);
    for (int i = 1; i < 6; i++) c[i] = cc(0, 0, 0, (i == 4 || i == 5) ? 2'h1 : 2'(i), i == 4);
    c[6] = cc(0, 1, 0, 0, 0);
    c[13] = c[5];
    for (int i = 8; i < 11; i++) c[i] = cc(1, 0, 2'(i - 7), 0, 0);
    // Start away from the match so no earlier event leaks in
    while (tval[0] !== 16'hfff8) tick(1);
    ccfg = c;
    dbl = 8'h20;
    si = nirq;
    st = ntog;
    sr = nrise;
    tick(64);
    chk(oe, 16'h003a);
    chk(16'(nirq[0] - si[0]), 16'h0004);
    chk(16'(ntog[0] - st[0]), 16'h0000);
    chk(16'(ntog[1] - st[1]), 16'h0004);
    chk(16'(nirq[2] - si[2]), 16'h0004);
    chk(16'(nrise[3] - sr[3]), 16'h0004);
    chk(16'(ntog[3] - st[3]), 16'h0007);
    chk(16'(ntog[4] - st[4]), 16'h0001);
    chk(16'(ntog[5] - st[5]), 16'h0008);
    chk(16'(nirq[6] - si[6]), 16'h0000);
    while (irq[2] !== 1'b1) tick(1);
    wrch(16'h0005, 16'hfffa);
    si = nirq;
    tick(8);
    chk(16'(nirq[0] - si[0]), 16'h0001);
    chk(16'(nirq[2] - si[2]), 16'h0000);
  endtask : t_modes
  task t_capture;
    drv = 16'h0700;
    v = tval[0];
    tick(1);
    chk(cval[8], v);
    chk(cval[10], v);
    chk(cval[9], CH_RESET);
    chk(irq & 16'h0700, 16'h0500);
    drv = '0;
    v = tval[0];
    tick(1);
    chk(cval[9], v);
    chk(irq & 16'h0700, 16'h0600);
  endtask : t_capture
  task t_rates;
    stag = 1'b1;
    tick(8);
    sc = chg;
    tick(32);
    chk(16'(chg[0] - sc[0]), 16'h0004);
    stag = 1'b0;
    tcfg[1] = tb(DTCCA_SRC_PRESCALE, 3'h2);
    tick(8);
    sc = chg;
    tick(32);
    chk(16'(chg[1] - sc[1]), 16'h0008);
    tcfg = {tb(DTCCA_SRC_NEIGHBOUR, 3'h0), tb(DTCCA_SRC_EXT, 3'h0)};
    tick(8);
    sc = chg;
    repeat (5) begin
      ext = 1'b1;
      neigh = 1'b1;
      tick(1);
      ext = 1'b0;
      neigh = 1'b0;
      tick(2);
    end
    tick(4);
    chk(16'(chg[0] - sc[0]), 16'h0005);
    chk(16'(chg[1] - sc[1]), 16'h0005);
  endtask : t_rates
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst, stag, neigh, ext, tcfg, rld, ccfg, wr, wdat, drv, dbl, pin_q, tv_q} = '0;
    rst = 1'b1;
    tick(16);
    rst = 1'b0;
    tick(1);
    t_reload();
    t_modes();
    t_capture();
    t_rates();
    finish_test();
  end
endmodule : dual_timer_capture_compare_array_bench
